// ===== verilog/anp_pkg.sv
package anp_pkg;

	// configuration word layout
	localparam int unsigned CFG_WIDTH = 12;
	localparam logic [11:0] FACTORY_CFG = 12'h0440;
	localparam int unsigned VOL_LSB = 0;
	localparam int unsigned VOL_MSB = 2;
	localparam int unsigned MONITOR_BIT = 3;
	localparam int unsigned MIX_BIT = 4;
	localparam int unsigned SE_EDIT_BIT = 5;
	localparam int unsigned SERIAL_FT_BIT = 6;
	localparam int unsigned OUT_SEL_BIT = 7;
	localparam int unsigned SPK_BIT = 8;
	localparam int unsigned OUT_PWR_BIT = 9;
	localparam int unsigned ALERT_BIT = 10;
	localparam int unsigned EOM_BIT = 11;

	// reset value of the serial-mode flag and the pin synchroniser
	localparam logic SERIAL_RESET = 1'b0;
	localparam logic PIN_N_RESET = 1'b1;

	typedef logic [11:0] anp_cfg_t;

	// control mode: pin or serial ownership of feed-through
	typedef enum logic [1:0]
	{
		MODE_STANDALONE = 2'b01,
		MODE_SERIAL     = 2'b10
	} anp_mode_t;

	// single field bit of a configuration word
	function automatic logic cfg_bit(input anp_cfg_t cfg, input int unsigned pos);
		cfg_bit = cfg[pos];
	endfunction

	// volume step code of a configuration word
	function automatic logic [2:0] cfg_volume(input anp_cfg_t cfg);
		cfg_volume = cfg[VOL_MSB:VOL_LSB];
	endfunction

endpackage

// ===== verilog/anp_nv_store.sv
`timescale 1ns/100ps

module anp_nv_store
(
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	input  wire logic              store_i,
	input  wire anp_pkg::anp_cfg_t data_i,
	output anp_pkg::anp_cfg_t      data_o,
	output logic                   done_o
);

	// nonvolatile cells: survive reset, factory value at power-up
	anp_pkg::anp_cfg_t cells_reg = anp_pkg::FACTORY_CFG;
	logic              done_reg;

	// permanent write of the offered word
	always_ff @(posedge clk_i)
	begin
		if (store_i)
			cells_reg <= data_i;
	end

	// one-cycle completion pulse
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			done_reg <= 1'b0;
		else
			done_reg <= store_i;
	end

	assign data_o = cells_reg;
	assign done_o = done_reg;

endmodule

// ===== verilog/anp_path_decode.sv
`timescale 1ns/100ps

module anp_path_decode
(
	input  wire anp_pkg::anp_cfg_t cfg_i,
	input  wire logic              feed_on_i,
	input  wire logic              op_record_i,
	input  wire logic              op_play_i,
	output logic                   rec_mic_o,
	output logic                   rec_aux_o,
	output logic                   out_mic_o,
	output logic                   out_aux_o,
	output logic                   out_stored_o
);

	logic mix;
	logic mon;

	assign mix = anp_pkg::cfg_bit(cfg_i, anp_pkg::MIX_BIT);
	assign mon = anp_pkg::cfg_bit(cfg_i, anp_pkg::MONITOR_BIT);

	// path selection per operating state
	always_comb
	begin
		rec_mic_o = 1'b0;
		rec_aux_o = 1'b0;
		out_mic_o = 1'b0;
		out_aux_o = 1'b0;
		out_stored_o = 1'b0;
		if (op_record_i)
		begin
			// record source from mix bit and feed-through
			rec_mic_o = !feed_on_i || mix;
			rec_aux_o = feed_on_i;
			// monitor copies the record source to outputs
			out_mic_o = mon && (!feed_on_i || mix);
			out_aux_o = mon && feed_on_i;
		end
		else if (op_play_i)
		begin
			out_stored_o = 1'b1;
			out_aux_o = feed_on_i;
		end
		else
		begin
			out_aux_o = feed_on_i;
			out_mic_o = feed_on_i && mix;
		end
	end

endmodule

// ===== verilog/anp_config_reg.sv
`timescale 1ns/100ps

module anp_config_reg
(
	input  wire logic        CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic        FEED_THROUGH_PIN_N_I,
	input  wire logic        SERIAL_POWER_UP_CMD_I,
	input  wire logic        POWER_DOWN_CMD_I,
	input  wire logic        RESET_FN_I,
	input  wire logic        CFG_LOAD_I,
	input  wire logic [11:0] CFG_DATA_I,
	input  wire logic        CFG_STORE_I,
	input  wire logic        OP_RECORD_I,
	input  wire logic        OP_PLAY_I,
	output logic      [11:0] CFG_DATA_O,
	output logic             CFG_STORE_DONE_O,
	output logic             SERIAL_MODE_O,
	output logic             FEED_THROUGH_ON_O,
	output logic             REC_MIC_O,
	output logic             REC_AUX_O,
	output logic             OUT_MIC_O,
	output logic             OUT_AUX_O,
	output logic             OUT_STORED_O,
	output logic       [2:0] VOLUME_STEP_O,
	output logic             CURRENT_OUT_EN_O,
	output logic             VOLTAGE_OUT_EN_O,
	output logic             SPEAKER_EN_O,
	output logic             SE_EDIT_EN_O,
	output logic             ALERT_EN_O,
	output logic             END_MARKER_STOP_O
);

	anp_pkg::anp_cfg_t  analog_path_config_reg;
	anp_pkg::anp_cfg_t  analog_path_config_next;
	anp_pkg::anp_cfg_t  nonvolatile_config_bits;
	anp_pkg::anp_mode_t mode_reg;
	anp_pkg::anp_mode_t mode_next;
	logic               reload_pending_reg;
	logic               pin_meta_n_reg;
	logic               pin_sync_n_reg;
	logic               feed_on;
	logic               store_done;

	// path decode results and their output flops
	logic               rec_mic;
	logic               rec_aux;
	logic               out_mic;
	logic               out_aux;
	logic               out_stored;
	logic               rec_mic_reg;
	logic               rec_aux_reg;
	logic               out_mic_reg;
	logic               out_aux_reg;
	logic               out_stored_reg;
	logic               feed_on_reg;

	// field decode flops
	logic [2:0]         volume_reg;
	logic               current_en_reg;
	logic               voltage_en_reg;
	logic               speaker_en_reg;
	logic               se_edit_en_reg;
	logic               alert_en_reg;
	logic               eom_stop_reg;
	logic               store_done_reg;

	// current-mode driver on while selected and powered
	function automatic logic current_enable(input anp_pkg::anp_cfg_t cfg);
		current_enable = !anp_pkg::cfg_bit(cfg, anp_pkg::OUT_SEL_BIT)
			&& !anp_pkg::cfg_bit(cfg, anp_pkg::OUT_PWR_BIT);
	endfunction

	// voltage driver on while selected and powered
	function automatic logic voltage_enable(input anp_pkg::anp_cfg_t cfg);
		voltage_enable = anp_pkg::cfg_bit(cfg, anp_pkg::OUT_SEL_BIT)
			&& !anp_pkg::cfg_bit(cfg, anp_pkg::OUT_PWR_BIT);
	endfunction

	// nonvolatile copy of the configuration
	anp_nv_store u_nv
	(
		.clk_i  (CLK_I),
		.rstn_i (RESETN_I),
		.store_i(CFG_STORE_I),
		.data_i (analog_path_config_reg),
		.data_o (nonvolatile_config_bits),
		.done_o (store_done)
	);

	// feed-through pin synchroniser, active low pin
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			pin_meta_n_reg <= anp_pkg::PIN_N_RESET;
			pin_sync_n_reg <= anp_pkg::PIN_N_RESET;
		end
		else
		begin
			pin_meta_n_reg <= FEED_THROUGH_PIN_N_I;
			pin_sync_n_reg <= pin_meta_n_reg;
		end
	end

	// mode transitions: power-up wins over power-down
	always_comb
	begin
		mode_next = mode_reg;
		unique case (mode_reg)
			anp_pkg::MODE_STANDALONE:
			begin
				if (SERIAL_POWER_UP_CMD_I)
					mode_next = anp_pkg::MODE_SERIAL;
			end
			anp_pkg::MODE_SERIAL:
			begin
				if (POWER_DOWN_CMD_I && !SERIAL_POWER_UP_CMD_I)
					mode_next = anp_pkg::MODE_STANDALONE;
			end
			default:
			begin
				mode_next = anp_pkg::MODE_STANDALONE;
			end
		endcase
	end

	// mode register
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			mode_reg <= anp_pkg::MODE_STANDALONE;
		else
			mode_reg <= mode_next;
	end

	// feed-through owner: pin in standalone, bit 6 in serial
	always_comb
	begin
		if (mode_reg == anp_pkg::MODE_SERIAL)
			feed_on = !anp_pkg::cfg_bit(analog_path_config_reg, anp_pkg::SERIAL_FT_BIT);
		else
			feed_on = !pin_sync_n_reg;
	end

	// reload request that follows reset release
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			reload_pending_reg <= 1'b1;
		else
			reload_pending_reg <= 1'b0;
	end

	// configuration next value: reload beats host load
	always_comb
	begin
		analog_path_config_next = analog_path_config_reg;
		if (reload_pending_reg || RESET_FN_I)
			analog_path_config_next = nonvolatile_config_bits;
		else if (CFG_LOAD_I)
			analog_path_config_next = CFG_DATA_I;
	end

	// configuration register, factory value under reset
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			analog_path_config_reg <= anp_pkg::FACTORY_CFG;
		else
			analog_path_config_reg <= analog_path_config_next;
	end

	// path decode for the current operation
	anp_path_decode u_path
	(
		.cfg_i       (analog_path_config_reg),
		.feed_on_i   (feed_on),
		.op_record_i (OP_RECORD_I),
		.op_play_i   (OP_PLAY_I),
		.rec_mic_o   (rec_mic),
		.rec_aux_o   (rec_aux),
		.out_mic_o   (out_mic),
		.out_aux_o   (out_aux),
		.out_stored_o(out_stored)
	);

	// registered signal path controls
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			rec_mic_reg <= 1'b0;
			rec_aux_reg <= 1'b0;
			out_mic_reg <= 1'b0;
			out_aux_reg <= 1'b0;
			out_stored_reg <= 1'b0;
			feed_on_reg <= 1'b0;
		end
		else
		begin
			rec_mic_reg <= rec_mic;
			rec_aux_reg <= rec_aux;
			out_mic_reg <= out_mic;
			out_aux_reg <= out_aux;
			out_stored_reg <= out_stored;
			feed_on_reg <= feed_on;
		end
	end

	// volume step, code 0 loudest
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			volume_reg <= anp_pkg::FACTORY_CFG[anp_pkg::VOL_MSB:anp_pkg::VOL_LSB];
		else
			volume_reg <= anp_pkg::cfg_volume(analog_path_config_reg);
	end

	// output driver selection and power
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			current_en_reg <= current_enable(anp_pkg::FACTORY_CFG);
			voltage_en_reg <= voltage_enable(anp_pkg::FACTORY_CFG);
			speaker_en_reg <= !anp_pkg::FACTORY_CFG[anp_pkg::SPK_BIT];
		end
		else
		begin
			// selected driver enabled only while powered
			current_en_reg <= current_enable(analog_path_config_reg);
			voltage_en_reg <= voltage_enable(analog_path_config_reg);
			speaker_en_reg <= !anp_pkg::cfg_bit(analog_path_config_reg, anp_pkg::SPK_BIT);
		end
	end

	// feature controls
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			se_edit_en_reg <= !anp_pkg::FACTORY_CFG[anp_pkg::SE_EDIT_BIT];
			alert_en_reg <= !anp_pkg::FACTORY_CFG[anp_pkg::ALERT_BIT];
			eom_stop_reg <= anp_pkg::FACTORY_CFG[anp_pkg::EOM_BIT];
		end
		else
		begin
			se_edit_en_reg <= !anp_pkg::cfg_bit(analog_path_config_reg, anp_pkg::SE_EDIT_BIT);
			alert_en_reg <= !anp_pkg::cfg_bit(analog_path_config_reg, anp_pkg::ALERT_BIT);
			eom_stop_reg <= anp_pkg::cfg_bit(analog_path_config_reg, anp_pkg::EOM_BIT);
		end
	end

	// store acknowledge
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			store_done_reg <= 1'b0;
		else
			store_done_reg <= store_done;
	end

	// outputs straight from flip-flops, serial mode decoded from mode_reg
	assign CFG_DATA_O = analog_path_config_reg;
	assign CFG_STORE_DONE_O = store_done_reg;
	assign SERIAL_MODE_O = (mode_reg == anp_pkg::MODE_SERIAL);
	assign FEED_THROUGH_ON_O = feed_on_reg;

	// routing of the audio path
	assign REC_MIC_O = rec_mic_reg;
	assign REC_AUX_O = rec_aux_reg;
	assign OUT_MIC_O = out_mic_reg;
	assign OUT_AUX_O = out_aux_reg;
	assign OUT_STORED_O = out_stored_reg;

	// output drivers and feature controls
	assign VOLUME_STEP_O = volume_reg;
	assign CURRENT_OUT_EN_O = current_en_reg;
	assign VOLTAGE_OUT_EN_O = voltage_en_reg;
	assign SPEAKER_EN_O = speaker_en_reg;
	assign SE_EDIT_EN_O = se_edit_en_reg;
	assign ALERT_EN_O = alert_en_reg;
	assign END_MARKER_STOP_O = eom_stop_reg;

endmodule

// ===== bench/anp_config_chk.sv
`timescale 1ns/100ps

module anp_config_chk
(
	input wire logic        CLK_I,
	input wire logic        RESETN_I,
	input wire logic        FEED_THROUGH_PIN_N_I,
	input wire logic        SERIAL_POWER_UP_CMD_I,
	input wire logic        POWER_DOWN_CMD_I,
	input wire logic        RESET_FN_I,
	input wire logic        CFG_LOAD_I,
	input wire logic [11:0] CFG_DATA_I,
	input wire logic        CFG_STORE_I,
	input wire logic        OP_RECORD_I,
	input wire logic        OP_PLAY_I,
	input wire logic [11:0] CFG_DATA_O,
	input wire logic        CFG_STORE_DONE_O,
	input wire logic        SERIAL_MODE_O,
	input wire logic        FEED_THROUGH_ON_O,
	input wire logic        REC_MIC_O,
	input wire logic        REC_AUX_O,
	input wire logic        OUT_MIC_O,
	input wire logic        OUT_AUX_O,
	input wire logic        OUT_STORED_O,
	input wire logic  [2:0] VOLUME_STEP_O,
	input wire logic        CURRENT_OUT_EN_O,
	input wire logic        VOLTAGE_OUT_EN_O,
	input wire logic        SPEAKER_EN_O,
	input wire logic        SE_EDIT_EN_O,
	input wire logic        ALERT_EN_O,
	input wire logic        END_MARKER_STOP_O
);
	// one clock domain, reset disables all
	default clocking dc @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);

	// host load, store and mode handshakes
	host_load_a: assert property (CFG_LOAD_I && !RESET_FN_I && $past(RESETN_I) |=> CFG_DATA_O == $past(CFG_DATA_I))
		else $error("loaded word not shown");
	store_done_a: assert property (CFG_STORE_I |-> ##2 CFG_STORE_DONE_O)
		else $error("store done missing");
	done_cause_a: assert property (CFG_STORE_DONE_O |-> $past(CFG_STORE_I, 2))
		else $error("store done without store");
	serial_enter_a: assert property (SERIAL_POWER_UP_CMD_I |=> SERIAL_MODE_O)
		else $error("serial mode not entered");
	serial_leave_a: assert property (POWER_DOWN_CMD_I && !SERIAL_POWER_UP_CMD_I |=> !SERIAL_MODE_O)
		else $error("serial mode not left");
	serial_feed_a: assert property (SERIAL_MODE_O |=> FEED_THROUGH_ON_O == !$past(CFG_DATA_O[6]))
		else $error("serial feed-through wrong");

	// field and path decode follow one cycle later, pin feed-through three cycles after the pin
	volume_step_a: assert property (VOLUME_STEP_O == $past(CFG_DATA_O[2:0]))
		else $error("volume step wrong");
	driver_sel_a: assert property (CURRENT_OUT_EN_O == (!$past(CFG_DATA_O[7]) && !$past(CFG_DATA_O[9]))
		&& VOLTAGE_OUT_EN_O == ($past(CFG_DATA_O[7]) && !$past(CFG_DATA_O[9]))
		&& SPEAKER_EN_O == !$past(CFG_DATA_O[8]))
		else $error("output driver select wrong");
	feature_bits_a: assert property (SE_EDIT_EN_O == !$past(CFG_DATA_O[5])
		&& ALERT_EN_O == !$past(CFG_DATA_O[10])
		&& END_MARKER_STOP_O == $past(CFG_DATA_O[11]))
		else $error("feature decode wrong");
	play_path_a: assert property (OP_PLAY_I && !OP_RECORD_I |=> OUT_STORED_O && !REC_MIC_O && !REC_AUX_O && !OUT_MIC_O)
		else $error("playback path wrong");
	idle_path_a: assert property (!OP_RECORD_I && !OP_PLAY_I |=> OUT_AUX_O == FEED_THROUGH_ON_O
		&& OUT_MIC_O == (FEED_THROUGH_ON_O && $past(CFG_DATA_O[4])) && !OUT_STORED_O && !REC_MIC_O && !REC_AUX_O)
		else $error("idle path wrong");
	pin_feed_a: assert property ($past(RESETN_I) && $past(RESETN_I, 2) && $past(RESETN_I, 3)
		&& !$past(SERIAL_MODE_O) |-> FEED_THROUGH_ON_O == !$past(FEED_THROUGH_PIN_N_I, 3))
		else $error("pin feed-through wrong");

	// main scenarios
	cover property (CFG_STORE_DONE_O);
	cover property (SERIAL_MODE_O && OP_PLAY_I);
	cover property (OP_RECORD_I && FEED_THROUGH_ON_O);
endmodule

bind anp_config_reg anp_config_chk i_anp_config_chk
(
	.CLK_I(CLK_I), .RESETN_I(RESETN_I), .SERIAL_POWER_UP_CMD_I(SERIAL_POWER_UP_CMD_I),
	.FEED_THROUGH_PIN_N_I(FEED_THROUGH_PIN_N_I), .OUT_AUX_O(OUT_AUX_O), .ALERT_EN_O(ALERT_EN_O),
	.POWER_DOWN_CMD_I(POWER_DOWN_CMD_I), .RESET_FN_I(RESET_FN_I), .CFG_LOAD_I(CFG_LOAD_I),
	.CFG_DATA_I(CFG_DATA_I), .CFG_STORE_I(CFG_STORE_I), .OP_RECORD_I(OP_RECORD_I), .OP_PLAY_I(OP_PLAY_I),
	.CFG_DATA_O(CFG_DATA_O), .CFG_STORE_DONE_O(CFG_STORE_DONE_O), .SERIAL_MODE_O(SERIAL_MODE_O),
	.FEED_THROUGH_ON_O(FEED_THROUGH_ON_O), .REC_MIC_O(REC_MIC_O), .REC_AUX_O(REC_AUX_O),
	.OUT_MIC_O(OUT_MIC_O), .OUT_STORED_O(OUT_STORED_O), .VOLUME_STEP_O(VOLUME_STEP_O),
	.CURRENT_OUT_EN_O(CURRENT_OUT_EN_O), .VOLTAGE_OUT_EN_O(VOLTAGE_OUT_EN_O), .SPEAKER_EN_O(SPEAKER_EN_O),
	.SE_EDIT_EN_O(SE_EDIT_EN_O), .END_MARKER_STOP_O(END_MARKER_STOP_O)
);

// ===== bench/anp_host_model.sv
`timescale 1ns/100ps

module anp_host_model
(
	input  wire logic        clk_i,
	output logic             pin_n_o,
	output logic             pwr_up_o,
	output logic             pwr_dn_o,
	output logic             reset_fn_o,
	output logic             load_o,
	output logic             store_o,
	output logic      [11:0] data_o,
	output logic             rec_o,
	output logic             play_o
);
	// idle levels at time zero
	initial
	begin
		pin_n_o = 1'b1;
		pwr_up_o = 1'b0;
		pwr_dn_o = 1'b0;
		reset_fn_o = 1'b0;
		load_o = 1'b0;
		store_o = 1'b0;
		rec_o = 1'b0;
		play_o = 1'b0;
		data_o = 12'h0000;
	end

	// one-cycle strobe: bit0 power-up, bit1 power-down, bit2 reset fn, bit3 store
	task cmd(input logic [3:0] c);
		@(negedge clk_i);
		pwr_up_o = c[0];
		pwr_dn_o = c[1];
		reset_fn_o = c[2];
		store_o = c[3];
		@(negedge clk_i);
		pwr_up_o = 1'b0;
		pwr_dn_o = 1'b0;
		reset_fn_o = 1'b0;
		store_o = 1'b0;
	endtask

	// whole-word load; released data is inverted
	task load(input logic [11:0] w);
		@(negedge clk_i);
		load_o = 1'b1;
		data_o = w;
		@(negedge clk_i);
		load_o = 1'b0;
		data_o = ~w;
	endtask

	// operation levels and push pin
	task lines(input logic r, input logic p, input logic n);
		@(negedge clk_i);
		rec_o = r;
		play_o = p;
		pin_n_o = n;
	endtask
endmodule

// ===== bench/anp_config_reg_tb.sv
`timescale 1ns/100ps

module anp_config_reg_tb;
	logic        clk, rstn, pin_n, pup, pdn, rfn, ld, st, rec, ply, done, ser, ft;
	logic        rmic, raux, omic, oaux, ostr, cur, volt, spk, sed, alr, eom, f;
	logic [11:0] din, dout, w;
	logic  [2:0] vol;
	logic  [4:0] e;
	int          fails = 0;
	int          samples_checked = 0;
	logic [11:0] words [4] = '{12'h0fff, 12'h0187, 12'h0a25, 12'h0000};

	// free-running clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	anp_host_model i_anp_host_model (.clk_i(clk), .pin_n_o(pin_n), .pwr_up_o(pup), .pwr_dn_o(pdn),
		.reset_fn_o(rfn), .load_o(ld), .store_o(st), .data_o(din), .rec_o(rec), .play_o(ply));
	anp_config_reg i_anp_config_reg (.CLK_I(clk), .RESETN_I(rstn), .FEED_THROUGH_PIN_N_I(pin_n),
		.SERIAL_POWER_UP_CMD_I(pup), .POWER_DOWN_CMD_I(pdn), .RESET_FN_I(rfn), .CFG_LOAD_I(ld),
		.CFG_DATA_I(din), .CFG_STORE_I(st), .OP_RECORD_I(rec), .OP_PLAY_I(ply), .CFG_DATA_O(dout),
		.CFG_STORE_DONE_O(done), .SERIAL_MODE_O(ser), .FEED_THROUGH_ON_O(ft), .REC_MIC_O(rmic),
		.REC_AUX_O(raux), .OUT_MIC_O(omic), .OUT_AUX_O(oaux), .OUT_STORED_O(ostr), .VOLUME_STEP_O(vol),
		.CURRENT_OUT_EN_O(cur), .VOLTAGE_OUT_EN_O(volt), .SPEAKER_EN_O(spk), .SE_EDIT_EN_O(sed),
		.ALERT_EN_O(alr), .END_MARKER_STOP_O(eom));

	// compare and count
	task chk(input logic [11:0] s, input logic [11:0] x);
		samples_checked++;
		if (s !== x)
		begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask

	// decoded fields of a settled word
	task outs(input logic [11:0] v);
		chk(vol, v[2:0]);
		chk({cur, volt}, {!v[7] && !v[9], v[7] && !v[9]});
		chk({spk, sed, alr, eom}, {!v[8], !v[5], !v[10], v[11]});
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		rstn = 1'b0;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		chk(dout, 12'h0440);
		outs(12'h0440);
		$display("test reset done");
		foreach (words[i])
		begin
			i_anp_host_model.load(words[i]);
			repeat (2) @(negedge clk);
			chk(dout, words[i]);
			outs(words[i]);
		end
		$display("test load done");
		i_anp_host_model.load(12'h05a3);
		i_anp_host_model.cmd(4'h8);
		chk(done, 1'b0);
		@(negedge clk);
		chk(done, 1'b1);
		@(negedge clk);
		chk(done, 1'b0);
		i_anp_host_model.load(12'h0000);
		i_anp_host_model.cmd(4'h4);
		chk(dout, 12'h05a3);
		rstn = 1'b0;
		@(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		chk(dout, 12'h05a3);
		$display("test store done");
		i_anp_host_model.load(12'h0450);
		i_anp_host_model.lines(1'b0, 1'b0, 1'b1);
		repeat (4) @(negedge clk);
		chk({ft, rmic, raux, omic, oaux, ostr}, 6'h00);
		i_anp_host_model.lines(1'b0, 1'b0, 1'b0);
		repeat (4) @(negedge clk);
		chk({ft, rmic, raux, omic, oaux, ostr}, 6'h26);
		i_anp_host_model.cmd(4'h1);
		repeat (2) @(negedge clk);
		chk({ser, ft}, 2'h2);
		for (int i = 0; i < 8; i++)
		begin
			w = {5'h08, i[2], 1'h0, i[1:0], 3'h0};
			i_anp_host_model.load(w);
			f = !w[6];
			for (int op = 0; op < 3; op++)
			begin
				i_anp_host_model.lines(op == 1, op == 2, 1'b0);
				repeat (3) @(negedge clk);
				if (op == 1)
					e = {!f || w[4], f, w[3] && (!f || w[4]), w[3] && f, 1'b0};
				else if (op == 2)
					e = {4'h0 | f, 1'b1} << 0;
				else
					e = {2'h0, f && w[4], f, 1'b0};
				chk(ft, f);
				chk({rmic, raux, omic, oaux, ostr}, e);
			end
		end
		i_anp_host_model.cmd(4'h2);
		repeat (3) @(negedge clk);
		chk({ser, ft}, 2'h1);
		$display("test path done");
		close_out();
	end
endmodule
